// ==== hw/core_flow_irq_indirect.sv ====
// Program counter, return stack, interrupt control and indirect access.
// Assumes exec and event inputs come from logic on clk; pins are async.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Flags set regardless of any enable
// - Bit 7 gates every interrupt
// - Bit 6 enables EEPROM done interrupt
// - Bit 5 enables timer overflow interrupt
// - Bit 3 enables port change interrupt
// - Timer flag set by hardware, software clears
// - Bit 1 shows external interrupt occurred
// - Change flag re-sets while mismatch persists
// - Control register at both 0Bh, 8Bh
// - 13-bit counter, only low byte accessible
// - Low-byte loads copy upper bits from latch
// - Branch target 11 bits plus page bits
// - Page bits ignored on this device
// - Eight 13-bit entries, hidden pointer
// - Push on call/ack, pop on returns
// - Push and pop leave latch alone
// - Ninth push overwrites the first
// - Ninth pop repeats first pop value
// - No overflow or underflow indication
// - Indirect port redirects, stores nothing
// - Effective address is bank bit plus pointer
// - Self-addressed indirect read returns zero
// - Self-addressed indirect write does nothing
module core_flow_irq_indirect #(
  parameter int RAM_WORDS = 16,        // General data bytes behind pointer
  parameter bit PAGE_BITS_USED = 1'b0, // Larger parts honour page bits
  parameter bit EXT_RISING = 1'b1      // Active edge of the external pin
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire core_flow_pkg::exec_type exec,
  input wire core_flow_pkg::event_type events,
  input wire logic extIrqPin,
  input wire logic [3:0] changeSensePins,
  input wire logic portRead,
  output logic [12:0] pc,
  output logic irqRequest
);

  localparam int RAM_AW = $clog2(RAM_WORDS);

  ////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] irqCtrl;          // Enables and flags
  logic [4:0] pcHighLatch;      // Holding latch for upper counter bits
  logic [7:0] indirectPointer;  // Pointer for indirect access
  logic indirectBankBit;        // Upper bit of the indirect address
  logic [12:0] stack [core_flow_pkg::STACK_DEPTH];
  logic [2:0] stackPtr;         // Wraps on its own, never visible
  logic [7:0] ram [RAM_WORDS];
  logic [3:0] changeLatch;      // Pin value at the last port read
  logic eepromFlag;             // Write complete, held for the request

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic extSync1;
  logic extSync2;
  logic extSync3;               // Delayed copy for the edge detect
  logic [3:0] changeSync1;
  logic [3:0] changeSync2;

  // Two flops first; edge flops reset to the active level, so no edge after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      extSync1 <= EXT_RISING;
      extSync2 <= EXT_RISING;
      extSync3 <= EXT_RISING;
      changeSync1 <= 4'h0;
      changeSync2 <= 4'h0;
    end else begin
      extSync1 <= extIrqPin;
      extSync2 <= extSync1;
      extSync3 <= extSync2;
      changeSync1 <= changeSensePins;
      changeSync2 <= changeSync1;
    end
  end

  logic extEdge;                // One cycle per active pin edge
  logic mismatch;               // Any pin differs from its latch
  assign extEdge = EXT_RISING ? (extSync2 & ~extSync3)
                              : (~extSync2 & extSync3);
  assign mismatch = |(changeSync2 ^ changeLatch);

  ////////////////////////////////////////////////////////////////////
  // Address decode
  logic access;                 // Access phase of a transfer
  logic [8:0] idx;              // Word index from the byte address
  logic [8:0] effAddr;          // Indirect target
  logic [8:0] tgt;              // Register actually addressed
  logic selfRef;                // Indirect port points at itself
  logic [8:0] ramOff;
  logic ramHit;
  logic [RAM_AW-1:0] ramIdx;
  logic wrEn;
  logic pclWrite;

  assign access = psel & penable;
  assign idx = paddr[10:2];
  assign effAddr = {indirectBankBit, indirectPointer};
  assign tgt = (idx == core_flow_pkg::IDX_INDIRECT) ? effAddr : idx;
  assign selfRef = (idx == core_flow_pkg::IDX_INDIRECT) &&
                   (effAddr == core_flow_pkg::IDX_INDIRECT);
  assign ramOff = tgt - core_flow_pkg::IDX_RAM;
  assign ramHit = (tgt >= core_flow_pkg::IDX_RAM) &&
                  (ramOff < 9'(RAM_WORDS));
  assign ramIdx = ramOff[RAM_AW-1:0];
  assign wrEn = access & pwrite & pready & ~selfRef & ~paddr[11];
  // only the low byte is writable
  assign pclWrite = wrEn && (tgt == core_flow_pkg::IDX_PCL);

  logic irqHit;
  logic [7:0] readByte;
  logic mapped;

  assign irqHit = (tgt == core_flow_pkg::IDX_IRQ) ||
                  (tgt == core_flow_pkg::IDX_IRQ_MIRROR);

  // Read mux; upper counter bits have no address at all
  always_comb begin
    readByte = 8'h00;
    mapped = 1'b1;
    if (paddr[11]) begin
      mapped = 1'b0;
    end else if (selfRef) begin
      readByte = 8'h00;
    end else if (irqHit) begin
      readByte = irqCtrl;
    end else if (ramHit) begin
      readByte = ram[ramIdx];
    end else begin
      unique case (tgt)
        core_flow_pkg::IDX_PCL: readByte = pc[7:0];
        core_flow_pkg::IDX_POINTER: readByte = indirectPointer;
        core_flow_pkg::IDX_LATCH: readByte = {3'h0, pcHighLatch};
        core_flow_pkg::IDX_BANK:
          readByte = {indirectBankBit, 7'h00};
        default: mapped = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, answer registered
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // Ready drops after the completing edge
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Plain software registers
  always_ff @(posedge clk) begin
    if (srst) begin
      pcHighLatch <= core_flow_pkg::LATCH_RESET;
      indirectPointer <= core_flow_pkg::POINTER_RESET;
      indirectBankBit <= 1'b0;
    end else if (wrEn) begin
      if (tgt == core_flow_pkg::IDX_LATCH) begin
        pcHighLatch <= pwdata[4:0];
      end
      if (tgt == core_flow_pkg::IDX_POINTER) begin
        indirectPointer <= pwdata[7:0];
      end
      if (tgt == core_flow_pkg::IDX_BANK) begin
        indirectBankBit <= pwdata[core_flow_pkg::BIT_BANK];
      end
    end
  end

  // Data bytes reached directly or through the pointer
  always_ff @(posedge clk) begin
    if (wrEn && ramHit) begin
      ram[ramIdx] <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt control and flags
  logic [7:0] wrIrq;            // Write value or current value
  assign wrIrq = (wrEn && irqHit) ? pwdata[7:0] : irqCtrl;

  // Events OR in after the write, so a set beats a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      irqCtrl <= core_flow_pkg::IRQ_RESET;
    end else begin
      irqCtrl[7:3] <= wrIrq[7:3];
      irqCtrl[core_flow_pkg::BIT_TMRF] <=
        wrIrq[core_flow_pkg::BIT_TMRF] | events.timerOverflow;
      irqCtrl[core_flow_pkg::BIT_EXTF] <=
        wrIrq[core_flow_pkg::BIT_EXTF] | extEdge;
      irqCtrl[core_flow_pkg::BIT_CHGF] <=
        wrIrq[core_flow_pkg::BIT_CHGF] | mismatch;
    end
  end

  // Port read ends the mismatch by taking a fresh copy
  always_ff @(posedge clk) begin
    if (srst) begin
      changeLatch <= 4'h0;
    end else if (portRead) begin
      changeLatch <= changeSync2;
    end
  end

  // Write-complete flag lives elsewhere; hold it until acknowledged
  always_ff @(posedge clk) begin
    if (srst) begin
      eepromFlag <= 1'b0;
    end else begin
      eepromFlag <= events.eepromDone | (eepromFlag & ~exec.irqAck);
    end
  end

  // Registered request so the output comes from a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= irqCtrl[core_flow_pkg::BIT_GIE] & (
        (irqCtrl[core_flow_pkg::BIT_EEPROM_DONE_IRQ_ENABLE] & eepromFlag) |
        (irqCtrl[core_flow_pkg::BIT_TMRIE] &
         irqCtrl[core_flow_pkg::BIT_TMRF]) |
        (irqCtrl[core_flow_pkg::BIT_EXTIE] &
         irqCtrl[core_flow_pkg::BIT_EXTF]) |
        (irqCtrl[core_flow_pkg::BIT_CHGIE] &
         irqCtrl[core_flow_pkg::BIT_CHGF]));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program counter and return stack
  logic [1:0] pageBits;
  logic pushNow;
  logic popNow;
  assign pageBits = PAGE_BITS_USED ? pcHighLatch[4:3] : 2'b00;
  assign pushNow = exec.irqAck | exec.call;
  assign popNow = ~pushNow & ~exec.jump & exec.ret;

  // Acknowledge beats call, jump, return, low-byte write, step
  always_ff @(posedge clk) begin
    if (srst) begin
      pc <= core_flow_pkg::PC_RESET;
    end else if (exec.irqAck) begin
      pc <= core_flow_pkg::IRQ_VECTOR;
    end else if (exec.call || exec.jump) begin
      pc <= {pageBits, exec.target};
    end else if (exec.ret) begin
      pc <= stack[stackPtr - 3'd1];
    end else if (pclWrite) begin
      // no carry into the upper bits
      pc <= {pcHighLatch, pwdata[7:0]};
    end else if (exec.advance) begin
      pc <= pc + 13'd1;
    end
  end

  // Pointer wraps freely and raises nothing when it does
  always_ff @(posedge clk) begin
    if (srst) begin
      stackPtr <= 3'd0;
    end else if (pushNow) begin
      stack[stackPtr] <= pc;
      stackPtr <= stackPtr + 3'd1;
    end else if (popNow) begin
      stackPtr <= stackPtr - 3'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  gie_gate_a: assert property (@(posedge clk) disable iff (srst)
    !irqCtrl[7] |=> !irqRequest)
    else $error("request raised with global enable clear");
  timer_set_a: assert property (@(posedge clk) disable iff (srst)
    events.timerOverflow |=> irqCtrl[2])
    else $error("timer flag missed an overflow");
  ext_flag_a: assert property (@(posedge clk) disable iff (srst)
    extEdge |=> irqCtrl[1])
    else $error("pin flag missed an edge");
  change_flag_a: assert property (@(posedge clk) disable iff (srst)
    mismatch |=> irqCtrl[0])
    else $error("change flag clear during mismatch");
  mirror_read_a: assert property (@(posedge clk) disable iff (srst)
    access && !pready && !pwrite && !paddr[11] &&
    idx == core_flow_pkg::IDX_IRQ_MIRROR
    |=> prdata[7:0] == $past(irqCtrl))
    else $error("mirror address read wrong value");
  self_read_a: assert property (@(posedge clk) disable iff (srst)
    access && !pready && !pwrite && selfRef |=> prdata == 32'h0)
    else $error("self-addressed read not zero");
  call_load_a: assert property (@(posedge clk) disable iff (srst)
    exec.call && !exec.irqAck
    |=> pc[10:0] == $past(exec.target) && pc[12:11] == 2'b00)
    else $error("call target not loaded");
  pcl_load_a: assert property (@(posedge clk) disable iff (srst)
    pclWrite && !exec.irqAck && !exec.call && !exec.jump && !exec.ret
    |=> pc == {$past(pcHighLatch), $past(pwdata[7:0])})
    else $error("low byte write lost latch bits");
  push_pop_a: assert property (@(posedge clk) disable iff (srst)
    (exec.call && !exec.irqAck) ##1
    (exec.ret && !exec.call && !exec.jump && !exec.irqAck)
    |=> pc == $past(pc, 2))
    else $error("return did not restore pushed counter");
  latch_hold_a: assert property (@(posedge clk) disable iff (srst)
    (pushNow || popNow) && !wrEn |=> $stable(pcHighLatch))
    else $error("stack action changed the latch");

  call_cov_c: cover property (@(posedge clk) disable iff (srst)
    exec.call ##1 exec.ret);
  irq_cov_c: cover property (@(posedge clk) disable iff (srst)
    exec.irqAck ##[1:20] irqRequest);
  indirect_cov_c: cover property (@(posedge clk) disable iff (srst)
    access && pready && ramHit && idx == core_flow_pkg::IDX_INDIRECT);

endmodule

`default_nettype wire

// ==== include/core_flow_pkg.sv ====
// Shared constants and carrier types for the control-flow block.
// Assumes a single 125 MHz core clock and an APB master with 32-bit data.
package core_flow_pkg;
  // Register indexes; APB byte address is four times the index
  localparam logic [8:0] IDX_INDIRECT = 9'h000;
  localparam logic [8:0] IDX_PCL = 9'h002;
  localparam logic [8:0] IDX_BANK = 9'h003;
  localparam logic [8:0] IDX_POINTER = 9'h004;
  localparam logic [8:0] IDX_LATCH = 9'h00a;
  localparam logic [8:0] IDX_IRQ = 9'h00b;
  localparam logic [8:0] IDX_IRQ_MIRROR = 9'h08b;
  localparam logic [8:0] IDX_RAM = 9'h020;
  // Interrupt control and bank field positions
  localparam int BIT_GIE = 7;
  localparam int BIT_EEPROM_DONE_IRQ_ENABLE = 6;
  localparam int BIT_TMRIE = 5;
  localparam int BIT_EXTIE = 4;
  localparam int BIT_CHGIE = 3;
  localparam int BIT_TMRF = 2;
  localparam int BIT_EXTF = 1;
  localparam int BIT_CHGF = 0;
  localparam int BIT_BANK = 7;
  // Values after reset, interrupt vector and stack depth
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [4:0] LATCH_RESET = 5'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam int STACK_DEPTH = 8;
  // Requests from the instruction execution logic
  typedef struct packed {
    logic call;
    logic jump;
    logic ret;
    logic irqAck;
    logic advance;
    logic [10:0] target;
  } exec_type;
  // One-cycle events from peripherals on the core clock
  typedef struct packed {
    logic timerOverflow;
    logic eepromDone;
  } event_type;
endpackage

// ==== dv/exec_source_model.sv ====
// Model of execution logic and peripheral sources facing the flow block.
// Assumes the bench calls its tasks; every pulse lasts one clk cycle.
`timescale 1ns/1ns
`default_nettype none

module exec_source_model (
  input wire logic clk,
  output var core_flow_pkg::exec_type exec,
  output var core_flow_pkg::event_type events
);
  // Idle from time zero
  initial begin
    exec = '0;
    events = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // call, jump, return, acknowledge or step
  // An idle cycle follows, so no pulse is assigned twice in one step
  task automatic issue(input core_flow_pkg::exec_type op);
    @(posedge clk);
    exec <= op;
    @(posedge clk);
    exec <= '0;
  endtask

  // Two pulses on consecutive edges, a call met at once by a return
  task automatic issuePair(input core_flow_pkg::exec_type a, b);
    @(posedge clk);
    exec <= a;
    @(posedge clk);
    exec <= b;
    @(posedge clk);
    exec <= '0;
  endtask

  // timer overflow or EEPROM done condition
  task automatic raise(input core_flow_pkg::event_type ev);
    @(posedge clk);
    events <= ev;
    @(posedge clk);
    events <= '0;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_core_flow_irq_indirect.sv ====
// Self-checking bench for the control-flow and interrupt block.
// Assumes the APB slave answers with pready; exec comes from the model.
`timescale 1ns/1ns
`default_nettype none

module tb_core_flow_irq_indirect;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  core_flow_pkg::exec_type exec;
  core_flow_pkg::event_type events;
  logic extIrqPin = 1'b0;
  logic [3:0] changeSensePins = 4'h0;
  logic portRead = 1'b0;
  logic [12:0] pc;
  logic irqRequest;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] rdata; // Last read word
  logic rerr; // Last error response
  // Write index, data, read index, expected byte
  typedef struct packed {
    logic [8:0] wi;
    logic [7:0] wd;
    logic [8:0] ri;
    logic [7:0] ex;
  } row_type;
  localparam row_type ROWS [7] = '{
    '{9'h00b, 8'hf8, 9'h08b, 8'hf8}, '{9'h020, 8'h5a, 9'h020, 8'h5a},
    '{9'h004, 8'h20, 9'h000, 8'h5a}, '{9'h000, 8'h33, 9'h020, 8'h33},
    '{9'h004, 8'h00, 9'h000, 8'h00}, '{9'h000, 8'h77, 9'h020, 8'h33},
    '{9'h00b, 8'h00, 9'h00b, 8'h00}};

  always #4 clk = ~clk;

  core_flow_irq_indirect core_flow_irq_indirect_inst (.clk(clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec(exec), .events(events),
    .extIrqPin(extIrqPin), .changeSensePins(changeSensePins),
    .portRead(portRead), .pc(pc), .irqRequest(irqRequest));

  exec_source_model exec_source_model_inst (.clk(clk), .exec(exec),
    .events(events));

  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer; waits on pready, never on a cycle count
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register access by index; byte address is four times it
  task automatic wr(input logic [8:0] i, input logic [7:0] d);
    apb({1'b0, i, 2'b00}, 1'b1, d);
  endtask
  task automatic rdc(input string s, input logic [8:0] i, input logic [7:0] e);
    apb({1'b0, i, 2'b00}, 1'b0, 8'h00);
    check(s, rdata, {24'h000000, e});
  endtask

  // Pulse to the execution model, pc checked once it has landed
  task automatic op(input int k, input logic [10:0] t, input logic [12:0] e);
    exec_source_model_inst.issue({5'h10 >> k, t});
    #1;
    check("pc", {19'h0, pc}, {19'h0, e});
  endtask

  // Irq request settles one cycle after the control write
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk);
    check("irqRequest", {31'h0, irqRequest}, {31'h0, e});
  endtask

  task automatic pulsePortRead();
    @(posedge clk);
    portRead <= 1'b1;
    @(posedge clk);
    portRead <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check("pc reset", {19'h0, pc}, {19'h0, core_flow_pkg::PC_RESET});
    rdc("irq reset", 9'h00b, core_flow_pkg::IRQ_RESET);
    foreach (ROWS[r]) begin
      wr(ROWS[r].wi, ROWS[r].wd);
      rdc("row", ROWS[r].ri, ROWS[r].ex);
    end
    $display("test rows done");
    // Low byte write takes the upper bits from the latch
    wr(9'h00a, 8'h1f);
    wr(9'h002, 8'h40);
    #1;
    check("pc load", {19'h0, pc}, 32'h00001f40);
    rdc("pc low", 9'h002, 8'h40);
    op(0, 11'h7ff, 13'h07ff);
    op(1, 11'h123, 13'h0123);
    $display("test pc done");
    // EEPROM done held, enabled late, cleared by acknowledge
    wr(9'h00b, 8'h80);
    exec_source_model_inst.raise(2'b01);
    irqIs(1'b0);
    wr(9'h00b, 8'hc0);
    irqIs(1'b1);
    op(3, 11'h000, core_flow_pkg::IRQ_VECTOR);
    irqIs(1'b0);
    op(2, 11'h000, 13'h0123);
    op(4, 11'h000, 13'h0124);
    $display("test ack done");
    // Nine calls then nine returns around the circular stack
    for (int i = 1; i <= 9; i++) begin
      op(0, 11'h100 + 11'(i), 13'h0100 + 13'(i));
    end
    for (int k = 1; k <= 9; k++) begin
      op(2, 11'h000, (k == 9) ? 13'h0108 : 13'h0109 - 13'(k));
    end
    exec_source_model_inst.issuePair({5'h10, 11'h155}, {5'h04, 11'h000});
    #1;
    check("call ret", {19'h0, pc}, 32'h00000108);
    rdc("latch", 9'h00a, 8'h1f);
    $display("test stack done");
    // Timer flag set while masked, kept until software clears
    wr(9'h00b, 8'h00);
    exec_source_model_inst.raise(2'b10);
    rdc("timer flag", 9'h00b, 8'h04);
    wr(9'h00b, 8'h24);
    irqIs(1'b0);
    wr(9'h00b, 8'ha4);
    irqIs(1'b1);
    wr(9'h00b, 8'h84);
    irqIs(1'b0);
    wr(9'h00b, 8'ha0);
    rdc("timer clear", 9'h00b, 8'ha0);
    $display("test timer done");
    // External pin edge
    wr(9'h00b, 8'h90);
    rdc("no pin", 9'h00b, 8'h90);
    @(posedge clk);
    extIrqPin <= 1'b1;
    repeat (6) @(posedge clk);
    rdc("pin flag", 9'h00b, 8'h92);
    irqIs(1'b1);
    wr(9'h00b, 8'h00);
    $display("test pin done");
    // Change flag returns while the mismatch stays
    pulsePortRead();
    wr(9'h00b, 8'h88);
    @(posedge clk);
    changeSensePins <= 4'h5;
    repeat (5) @(posedge clk);
    wr(9'h00b, 8'h88);
    rdc("change kept", 9'h00b, 8'h89);
    irqIs(1'b1);
    pulsePortRead();
    repeat (2) @(posedge clk);
    wr(9'h00b, 8'h88);
    rdc("change clear", 9'h00b, 8'h88);
    $display("test change done");
    // Unmapped place refused; write leaves nothing behind
    apb(12'h800, 1'b1, 8'h55);
    check("err", {31'h0, rerr}, 32'h1);
    apb(12'h800, 1'b0, 8'h00);
    check("err data", rdata, 32'h0);
    $display("test unmapped done");
    // Mid-run reset with the pin held high and state set beforehand
    wr(9'h00b, 8'hff);
    wr(9'h004, 8'h21);
    irqIs(1'b1);
    @(posedge clk);
    srst <= 1'b1;
    changeSensePins <= 4'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check("pc rst", {19'h0, pc}, {19'h0, core_flow_pkg::PC_RESET});
    check("irq rst", {31'h0, irqRequest}, 32'h0);
    repeat (4) @(posedge clk);
    rdc("irq rst", 9'h00b, core_flow_pkg::IRQ_RESET);
    rdc("latch rst", 9'h00a, {3'h0, core_flow_pkg::LATCH_RESET});
    rdc("ptr rst", 9'h004, core_flow_pkg::POINTER_RESET);
    $display("test reset done");
    summarize();
  end

  // Watchdog well beyond the few hundred cycles of the run
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
